// ==== hdl/aofm_pkg.sv ====
// Package: shared types and constants for the analog output fault monitor
package aofm_pkg;
  // Fixed point: normalized values are Q1.16, physical values in mV or uA
  localparam int NW = 17;            // Normalized width, 0..65536
  localparam logic [16:0] NORM_ONE = 17'h10000;
  localparam int PW = 18;            // Physical signed width (mV / uA)
  // Voltage limits in mV, current limits in uA
  localparam logic signed [17:0] V_LIM_MIN = -18'sd10000;
  localparam logic signed [17:0] V_LIM_MAX = 18'sd10000;
  localparam logic signed [17:0] V_MIN_RST = 18'sd0;
  localparam logic signed [17:0] V_MAX_RST = 18'sd5000;
  localparam logic signed [17:0] I_LIM_MIN = -18'sd20000;
  localparam logic signed [17:0] I_LIM_MAX = 18'sd20000;
  localparam logic signed [17:0] I_MIN_RST = 18'sd4000;
  localparam logic signed [17:0] I_MAX_RST = 18'sd20000;
  // Monitor spans, read only
  localparam logic signed [17:0] VMON_MIN = -18'sd12000;
  localparam logic signed [17:0] VMON_SPAN = 18'sd24000;
  localparam logic signed [17:0] IMON_MIN = -18'sd25000;
  localparam logic signed [17:0] IMON_SPAN = 18'sd50000;
  localparam logic signed [17:0] IMON_VWIN = 18'sd8000;
  // Threshold in tenths of a percent, range 0..1000
  localparam logic [9:0] THR_RST = 10'h032;   // 5.0 percent
  localparam logic [9:0] THR_MAX = 10'h3E8;   // 100.0 percent
  localparam logic [9:0] THR_DIV = 10'h3E8;   // Percent*10 to fraction
  // Timing: 1 ms tick derived from the 125 MHz clock
  localparam int CLK_HZ = 125000000;
  localparam int TICK_US = 1000;
  localparam int TICK_CYC = CLK_HZ / 1000000 * TICK_US;
  localparam logic [16:0] TICK_CNT = 17'(TICK_CYC - 1);
  // Delays in ms, limited to 300 s
  localparam logic [18:0] DLY_MAX_MS = 19'h493E0;
  localparam logic [18:0] FAULT_DLY_RST = 19'h00014;     // 0.02 s
  localparam logic [18:0] SHUT_DLY_RST = 19'h01388;      // 5.0 s
  localparam logic [15:0] ERR_CODE_IMON = 16'h0000;

  typedef enum logic [1:0] {
    AOFM_ST_VALID = 2'h0,
    AOFM_ST_ERROR = 2'h1,
    AOFM_ST_NA = 2'h3
  } aofm_state_e;

  // Logical signal as carried between blocks
  typedef struct packed {
    aofm_state_e st;
    logic [15:0] code;
    logic [16:0] val;
  } aofm_sig_s;

  typedef struct packed {
    logic cur_mode;
    logic invert;
    logic shut_en;
    logic signed [17:0] v_min;
    logic signed [17:0] v_max;
    logic signed [17:0] i_min;
    logic signed [17:0] i_max;
    logic [9:0] thr;
    logic [18:0] fault_ms;
    logic [18:0] shut_ms;
  } aofm_cfg_s;

  typedef enum logic [1:0] {
    AOFM_OK = 2'b00,
    AOFM_FAULT = 2'b01,
    AOFM_SHUT = 2'b11
  } aofm_fsm_e;

  // Absolute value of a signed physical quantity
  function automatic logic [18:0] aofm_abs(input logic signed [18:0] x);
    return x[18] ? 19'(-x) : 19'(x);
  endfunction
endpackage

// ==== hdl/aofm_persist.sv ====
// Persistence timer: output follows condition after it holds a delay
module aofm_persist
  import aofm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timebase and delay
  input wire logic tick,
  input wire logic [18:0] delay_ms,
  // Condition in, filtered level out
  input wire logic cond,
  output logic level
);
  typedef struct packed {
    logic [18:0] cnt;
    logic lvl;
  } aofm_pers_s;
  aofm_pers_s s_r, s_nxt;

  // Count ms ticks while cond differs from level, restart otherwise
  always_comb begin
    s_nxt = s_r;
    if (cond == s_r.lvl) begin
      s_nxt.cnt = '0; // [R21]
    end else if (s_r.cnt >= delay_ms) begin
      s_nxt.lvl = cond; // [R9]
      s_nxt.cnt = '0;
    end else if (tick) begin
      s_nxt.cnt = s_r.cnt + 19'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level = s_r.lvl;
endmodule // aofm_persist

// ==== hdl/aofm_sync.sv ====
// Three-stage synchroniser for a bus of pin-side measurement bits
module aofm_sync
  import aofm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Asynchronous in, stable out
  input wire logic [17:0] d,
  output logic [17:0] q
);
  typedef struct packed {
    logic [17:0] s1;
    logic [17:0] s2;
    logic [17:0] s3;
    logic [17:0] q;
  } aofm_sync_s;
  aofm_sync_s s_r, s_nxt;

  // Accept a new value only once stages two and three agree
  always_comb begin
    s_nxt = s_r;
    s_nxt.s1 = d;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    if (s_r.s2 == s_r.s3) begin
      s_nxt.q = s_r.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign q = s_r.q;
endmodule // aofm_sync

// ==== hdl/aofm_top.sv ====
// Analog output command, monitor normalization and fault supervision
// Function
// R1 - One command input, three monitor/fault outputs
// R2 - Mode select, voltage drive by default
// R3 - Voltage range limits, defaults 0 and 5 V
// R4 - Current range limits, defaults 4 and 20 mA
// R5 - Voltage monitor normalized over +-12 V
// R6 - Current monitor normalized over +-25 mA
// R7 - Fault threshold percent, default 5.0
// R8 - Limit equals range width times percent/100
// R9 - Fault flag changes after programmable delay
// R10 - Flag set above limit, cleared at/below
// R11 - User sets delay covering settling time
// R12 - Optional shutdown after longer fault persistence
// R13 - Shutdown latched until power-up, flag held
// R14 - Current mode faults on monitor error too
// R15 - Current monitor errors outside +-8 V
// R16 - Voltage monitor always valid
// R17 - Optional command inversion; source selected upstream
// R18 - Global enable gates the physical output
// R19 - Command restored as x*width plus lower
// R20 - Error input carries zero, no inversion
// R21 - Timers restart if condition changes early
module aofm_top
  import aofm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Configuration
  input wire aofm_cfg_s cfg,
  input wire logic global_en,
  // Logical command input from the selected source
  input wire aofm_sig_s cmd_in,
  // Measured output from the converters, mV and uA, asynchronous
  input wire logic signed [17:0] meas_mv,
  input wire logic signed [17:0] meas_ua,
  // Physical drive to the output stage
  output logic drive_en,
  output logic drive_cur_mode,
  output logic signed [17:0] drive_val,
  // Logical outputs
  output aofm_sig_s vmon_out,
  output aofm_sig_s imon_out,
  output logic output_fault_flag
);
  typedef struct packed {
    logic [16:0] tick_cnt;
    logic tick;
    logic signed [17:0] drive;
    logic drive_en;
    logic cur_mode;
    aofm_sig_s vmon;
    aofm_sig_s imon;
    logic [18:0] dev;
    logic [18:0] lim;
    logic imon_err;
    aofm_fsm_e fsm;
  } aofm_top_s;
  aofm_top_s s_r, s_nxt;

  logic signed [17:0] mv_s, ua_s;
  logic fault_cond, fault_lvl, shut_lvl;
  logic signed [17:0] lo, hi, clip_lo, clip_hi;
  logic signed [18:0] width;
  logic [16:0] xn;
  logic signed [36:0] prod;
  logic signed [17:0] expect_v;
  logic signed [17:0] meas;
  logic [28:0] lim_wide;

  // Measurements come from outside the clock domain
  aofm_sync u_sync_v (
    .clk(clk),
    .rst(rst),
    .d(meas_mv),
    .q(mv_s)
  );
  aofm_sync u_sync_i (
    .clk(clk),
    .rst(rst),
    .d(meas_ua),
    .q(ua_s)
  );

  // Normalize a physical value over a fixed span, clipped to [0;1]
  function automatic logic [16:0] norm(input logic signed [17:0] v,
                                      input logic signed [17:0] vmin,
                                      input logic signed [17:0] span);
    logic signed [19:0] off;
    logic [36:0] q;
    off = 20'(v) - 20'(vmin);
    q = '0;
    if (off <= 0) begin
      return '0;
    end else if (off >= 20'(span)) begin
      return NORM_ONE;
    end
    q = (37'(off) << 16) / 37'(span);
    return q[16:0];
  endfunction

  // Clamp a configured limit into its legal range
  function automatic logic signed [17:0] clamp(input logic signed [17:0] v,
                                               input logic signed [17:0] lo_l,
                                               input logic signed [17:0] hi_l);
    if (v < lo_l) begin
      return lo_l;
    end else if (v > hi_l) begin
      return hi_l;
    end
    return v;
  endfunction

  // Range limits of the active mode; a reversed pair is held at defaults
  always_comb begin
    if (cfg.cur_mode) begin // [R2]
      clip_lo = clamp(cfg.i_min, I_LIM_MIN, I_LIM_MAX); // [R4]
      clip_hi = clamp(cfg.i_max, I_LIM_MIN, I_LIM_MAX);
      lo = (clip_hi > clip_lo) ? clip_lo : I_MIN_RST;
      hi = (clip_hi > clip_lo) ? clip_hi : I_MAX_RST;
    end else begin
      clip_lo = clamp(cfg.v_min, V_LIM_MIN, V_LIM_MAX); // [R3]
      clip_hi = clamp(cfg.v_max, V_LIM_MIN, V_LIM_MAX);
      lo = (clip_hi > clip_lo) ? clip_lo : V_MIN_RST;
      hi = (clip_hi > clip_lo) ? clip_hi : V_MAX_RST;
    end
    width = 19'(hi) - 19'(lo);
  end

  // Command value: invalid input reads as zero with no inversion
  always_comb begin
    if (cmd_in.st != AOFM_ST_VALID) begin
      xn = '0; // [R20]
    end else if (cfg.invert) begin
      xn = NORM_ONE - cmd_in.val; // [R17]
    end else begin
      xn = cmd_in.val;
    end
    prod = 37'(width) * $signed({20'h00000, xn});
    expect_v = 18'(prod >>> 16) + lo; // [R19]
  end

  // Limit: width * percent / 100, threshold held in tenths of a percent
  always_comb begin
    lim_wide = 29'(width) * 29'(cfg.thr > THR_MAX ? THR_MAX : cfg.thr);
    lim_wide = lim_wide / 29'(THR_DIV); // [R7] [R8]
    meas = cfg.cur_mode ? ua_s : mv_s;
  end

  // Compare inputs are registered, so the flag lags the synchronised measurement by three cycles when the fault delay is zero
  assign fault_cond = (s_r.dev > s_r.lim) ||
                      (s_r.cur_mode && s_r.imon_err); // [R10] [R14]

  aofm_persist u_fault (
    .clk(clk),
    .rst(rst),
    .tick(s_r.tick),
    .delay_ms(cfg.fault_ms > DLY_MAX_MS ? DLY_MAX_MS : cfg.fault_ms),
    .cond(fault_cond),
    .level(fault_lvl)
  );
  aofm_persist u_shut (
    .clk(clk),
    .rst(rst),
    .tick(s_r.tick),
    .delay_ms(cfg.shut_ms > DLY_MAX_MS ? DLY_MAX_MS : cfg.shut_ms),
    .cond(fault_cond && cfg.shut_en),
    .level(shut_lvl)
  );

  // Next state of the whole block
  always_comb begin
    s_nxt = s_r;
    // Millisecond tick for the persistence timers
    s_nxt.tick = (s_r.tick_cnt == TICK_CNT);
    s_nxt.tick_cnt = s_nxt.tick ? '0 : s_r.tick_cnt + 17'h00001;
    s_nxt.cur_mode = cfg.cur_mode;
    // Monitors
    s_nxt.vmon.st = AOFM_ST_VALID; // [R16]
    s_nxt.vmon.code = '0;
    s_nxt.vmon.val = norm(mv_s, VMON_MIN, VMON_SPAN); // [R5]
    s_nxt.imon_err = (mv_s > IMON_VWIN) || (mv_s < -IMON_VWIN); // [R15]
    if (s_nxt.imon_err) begin
      s_nxt.imon.st = AOFM_ST_ERROR;
      s_nxt.imon.code = ERR_CODE_IMON;
      s_nxt.imon.val = '0; // [R20]
    end else begin
      s_nxt.imon.st = AOFM_ST_VALID;
      s_nxt.imon.code = '0;
      s_nxt.imon.val = norm(ua_s, IMON_MIN, IMON_SPAN); // [R6]
    end
    // Deviation between expected and measured output
    s_nxt.dev = aofm_abs(19'(expect_v) - 19'(meas));
    s_nxt.lim = lim_wide[18:0];
    // Supervision state machine; shutdown only left by power-up
    case (s_r.fsm)
      AOFM_OK: begin
        if (shut_lvl) begin
          s_nxt.fsm = AOFM_SHUT; // [R12]
        end else if (fault_lvl) begin
          s_nxt.fsm = AOFM_FAULT;
        end
      end
      AOFM_FAULT: begin
        if (shut_lvl) begin
          s_nxt.fsm = AOFM_SHUT; // [R12]
        end else if (!fault_lvl) begin
          s_nxt.fsm = AOFM_OK;
        end
      end
      AOFM_SHUT: s_nxt.fsm = AOFM_SHUT; // [R13]
      default: s_nxt.fsm = AOFM_OK;
    endcase
    // Output drive: forced to zero after shutdown
    if (s_nxt.fsm == AOFM_SHUT) begin
      s_nxt.drive = '0; // [R13]
      s_nxt.drive_en = 1'b0;
    end else begin
      s_nxt.drive = expect_v;
      s_nxt.drive_en = global_en; // [R18]
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign drive_en = s_r.drive_en;
  assign drive_cur_mode = s_r.cur_mode;
  assign drive_val = s_r.drive;
  assign vmon_out = s_r.vmon; // [R1]
  assign imon_out = s_r.imon;
  assign output_fault_flag = (s_r.fsm != AOFM_OK); // [R10] [R13]
endmodule // aofm_top

// ==== testbench/aofm_load_model.sv ====
// Resistive load model on the analog output
module aofm_load_model
  import aofm_pkg::*;
(
  // Drive from the block
  input wire logic drive_en,
  input wire logic drive_cur_mode,
  input wire logic signed [17:0] drive_val,
  // Fault knobs set by the bench
  input wire logic signed [17:0] err_mv,
  input wire logic open_ckt,
  // Measured output
  output logic signed [17:0] meas_mv,
  output logic signed [17:0] meas_ua
);
  timeunit 1ns;
  timeprecision 1ps;
  logic signed [17:0] v_ld;
  // 250 ohm load settles at once; offset stands for a gain fault
  always_comb begin
    v_ld = drive_en ? drive_val : 18'sh0;
    meas_mv = (drive_cur_mode ? v_ld >>> 2 : v_ld) + err_mv;
    meas_ua = drive_cur_mode ? v_ld : v_ld <<< 2;
    if (drive_cur_mode && open_ckt) begin
      meas_ua = 18'sh0;
      meas_mv = 18'sh2328;
    end
  end
endmodule // aofm_load_model

// ==== testbench/aofm_top_asserts.sv ====
// Port-level checks for the analog output fault monitor
module aofm_top_asserts
  import aofm_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Block inputs
  input wire aofm_cfg_s cfg,
  input wire logic global_en,
  input wire aofm_sig_s cmd_in,
  input wire logic signed [17:0] meas_mv,
  input wire logic signed [17:0] meas_ua,
  // Block outputs
  input wire logic drive_en,
  input wire logic drive_cur_mode,
  input wire logic signed [17:0] drive_val,
  input wire aofm_sig_s vmon_out,
  input wire aofm_sig_s imon_out,
  input wire logic output_fault_flag
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single domain
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_gate_off;
    !global_en |=> !drive_en;
  endproperty
  a_gate_off: assert property (p_gate_off)
    else $error("drive on while disabled");
  // Only a shutdown, which also zeroes the drive, may hold the output off
  property p_gate_on;
    global_en |=> drive_en || (output_fault_flag && drive_val == 18'sh0);
  endproperty
  a_gate_on: assert property (p_gate_on)
    else $error("drive off without cause");
  property p_vmon_ok;
    vmon_out.st == AOFM_ST_VALID;
  endproperty
  a_vmon_ok: assert property (p_vmon_ok)
    else $error("voltage monitor not valid");
  property p_imon_code;
    imon_out.st == AOFM_ST_ERROR |->
      imon_out.code == ERR_CODE_IMON && imon_out.val == 17'h0;
  endproperty
  a_imon_code: assert property (p_imon_code)
    else $error("current monitor error code or value wrong");
  property p_imon_err;
    (meas_mv > IMON_VWIN) [*7] |-> imon_out.st == AOFM_ST_ERROR;
  endproperty
  a_imon_err: assert property (p_imon_err)
    else $error("current monitor missed high voltage");
  property p_open_fault;
    (cfg.cur_mode && cfg.fault_ms == 19'h0 && meas_mv > IMON_VWIN) [*8]
      |-> ##[0:4] output_fault_flag;
  endproperty
  a_open_fault: assert property (p_open_fault)
    else $error("no fault on current monitor error");
  property p_shut_hold;
    cfg.shut_en && output_fault_flag && !drive_en && global_en
      && $past(global_en) |=>
      !drive_en && output_fault_flag && drive_val == 18'sh0;
  endproperty
  a_shut_hold: assert property (p_shut_hold)
    else $error("shutdown released");
  property p_bad_cmd;
    cmd_in.st != AOFM_ST_VALID && !cfg.cur_mode && drive_en && global_en
      |=> drive_val == $past(cfg.v_min);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd)
    else $error("invalid command not taken as zero");
endmodule // aofm_top_asserts

bind aofm_top aofm_top_asserts chk_u (.clk, .rst, .cfg, .global_en,
  .cmd_in, .meas_mv, .meas_ua, .drive_en, .drive_cur_mode, .drive_val,
  .vmon_out, .imon_out, .output_fault_flag);

// ==== testbench/aofm_top_tb_top.sv ====
// Self-checking bench for the analog output fault monitor
module aofm_top_tb_top
  import aofm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  aofm_cfg_s cfg;
  aofm_sig_s cmd_in, vmon_out, imon_out;
  logic global_en, drive_en, drive_cur_mode, output_fault_flag, open_ckt;
  logic signed [17:0] meas_mv, meas_ua, drive_val, err_mv;
  int n_mismatch = 0;
  int n_checks = 0;
  // 125 MHz clock
  always #4 clk = ~clk;
  aofm_top dut_u (.clk, .rst, .cfg, .global_en, .cmd_in, .meas_mv,
    .meas_ua, .drive_en, .drive_cur_mode, .drive_val, .vmon_out,
    .imon_out, .output_fault_flag);
  aofm_load_model load_u (.drive_en, .drive_cur_mode, .drive_val,
    .err_mv, .open_ckt, .meas_mv, .meas_ua);
  // Step n edges, then 1 ns so drives and samples stay off the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // Zero delays: a 1 ms tick would make real delays far too long
  task automatic set_dflt();
    cfg = '{1'b0, 1'b0, 1'b0, V_MIN_RST, V_MAX_RST, I_MIN_RST, I_MAX_RST,
      THR_RST, 19'h0, 19'h0};
  endtask
  task automatic do_reset();
    rst = 1'b1;
    tick(3);
    chk(35'(drive_en), 35'h0);
    chk(35'(output_fault_flag), 35'h0);
    rst = 1'b0;
    tick(1);
  endtask
  task automatic t_scale();
    cmd_in = '{AOFM_ST_VALID, 16'h0, 17'h04000};
    tick(2);
    chk(35'(drive_val), 35'(18'h004E2));
    cfg.invert = 1'b1;
    tick(2);
    chk(35'(drive_val), 35'(18'h00EA6));
    cmd_in.st = AOFM_ST_ERROR;
    tick(2);
    chk(35'(drive_val), 35'h0);
    // Reversed pair falls back to the mode defaults
    set_dflt();
    cfg.v_min = 18'sd3000;
    cfg.v_max = 18'sd1000;
    cmd_in = '{AOFM_ST_VALID, 16'h0, 17'h04000};
    tick(2);
    chk(35'(drive_val), 35'(18'h004E2));
    set_dflt();
    cfg.cur_mode = 1'b1;
    cfg.i_min = 18'sh0;
    cmd_in = '{AOFM_ST_VALID, 16'h0, 17'h0A000};
    tick(2);
    chk(35'(drive_val), 35'(18'h030D4));
    chk(35'(drive_cur_mode), 35'h1);
    tick(12);
    chk(imon_out, {AOFM_ST_VALID, 16'h0, 17'h0C000});
    set_dflt();
  endtask
  task automatic t_fault();
    cmd_in.val = 17'h0;
    tick(12);
    chk(vmon_out, {AOFM_ST_VALID, 16'h0, 17'h08000});
    cmd_in.val = 17'h08000;
    err_mv = 18'sh0012C;
    tick(12);
    chk(35'(drive_val), 35'(18'h009C4));
    chk(35'(output_fault_flag), 35'h1);
    err_mv = 18'sh000FA;
    tick(12);
    chk(35'(output_fault_flag), 35'h0);
    err_mv = 18'sh0012C;
    cfg.thr = 10'h064;
    tick(12);
    chk(35'(output_fault_flag), 35'h0);
    // Nonzero delay: no 1 ms tick falls inside this short run
    cfg.thr = THR_RST;
    cfg.fault_ms = 19'h00001;
    tick(12);
    chk(35'(output_fault_flag), 35'h0);
    err_mv = 18'sh0;
    set_dflt();
  endtask
  // Zero command and lower limit, so only the monitor error can fault
  task automatic t_open();
    cfg.cur_mode = 1'b1;
    cfg.i_min = 18'sh0;
    cmd_in.val = 17'h0;
    open_ckt = 1'b1;
    tick(12);
    chk(imon_out, {AOFM_ST_ERROR, 33'h0});
    chk(35'(output_fault_flag), 35'h1);
    open_ckt = 1'b0;
    tick(12);
    chk(35'(output_fault_flag), 35'h0);
    set_dflt();
  endtask
  task automatic t_shut();
    cmd_in.val = 17'h08000;
    global_en = 1'b0;
    tick(2);
    chk(35'(drive_en), 35'h0);
    // Let the output settle before shutdown is armed
    global_en = 1'b1;
    tick(12);
    chk(35'(output_fault_flag), 35'h0);
    cfg.shut_en = 1'b1;
    err_mv = 18'sh0012C;
    tick(12);
    chk(35'(drive_en), 35'h0);
    chk(35'(drive_val), 35'h0);
    // Matching command and measurement must not lift the latch
    cmd_in.val = 17'h0;
    err_mv = 18'sh0;
    tick(12);
    chk(35'(output_fault_flag), 35'h1);
    chk(35'(drive_en), 35'h0);
    set_dflt();
    do_reset();
    tick(2);
    chk(35'(drive_en), 35'h1);
  endtask
  // Hang guard, far beyond the roughly 150 cycles of the run
  initial begin
    #20us;
    n_mismatch++;
    wrap_up();
  end
  // Main sequence
  initial begin
    set_dflt();
    global_en = 1'b1;
    cmd_in = '{AOFM_ST_VALID, 16'h0, 17'h0};
    err_mv = 18'sh0;
    open_ckt = 1'b0;
    do_reset();
    t_scale();
    t_fault();
    t_open();
    t_shut();
    wrap_up();
  end
endmodule // aofm_top_tb_top
